// ===== core/jtp_map.svh
// Constants for the boundary-scan test port pin logic
`ifndef JTP_MAP_SVH
`define JTP_MAP_SVH

// Instruction register width and its reset value
`define JTP_IR_WIDTH 4
`define JTP_IR_RESET 4'h1

// Pattern loaded into the instruction shifter in the capture state
`define JTP_IR_CAPTURE 4'h1

// Bypass stage value loaded in the data capture state
`define JTP_BYPASS_CAPTURE 1'h0

// Stages of the pin synchroniser
`define JTP_SYNC_STAGES 2

// Reset values of the serial output and its enable
`define JTP_TDO_RESET 1'h0
`define JTP_TDO_OE_RESET 1'h0

`endif

// ===== core/jtp_pkg.sv
// Types shared by the boundary-scan test port pin logic
`default_nettype none
package jtp_pkg;

   // Pins driven by the external tester; *_drv is high while driven
   typedef struct packed {
      logic tck;
      logic tms;
      logic tms_drv;
      logic tdi;
      logic tdi_drv;
      logic trst_n;
   } jtp_pins_type;

   // Serial output pin: data and output enable
   typedef struct packed {
      logic data;
      logic oe;
   } jtp_tdo_type;

   // Controller states, sixteen in all
   typedef enum logic [3:0] {
      JTP_TLR        = 4'h0,
      JTP_RTI        = 4'h1,
      JTP_SEL_DR     = 4'h2,
      JTP_CAPTURE_DR = 4'h3,
      JTP_SHIFT_DR   = 4'h4,
      JTP_EXIT1_DR   = 4'h5,
      JTP_PAUSE_DR   = 4'h6,
      JTP_EXIT2_DR   = 4'h7,
      JTP_UPDATE_DR  = 4'h8,
      JTP_SEL_IR     = 4'h9,
      JTP_CAPTURE_IR = 4'ha,
      JTP_SHIFT_IR   = 4'hb,
      JTP_EXIT1_IR   = 4'hc,
      JTP_PAUSE_IR   = 4'hd,
      JTP_EXIT2_IR   = 4'he,
      JTP_UPDATE_IR  = 4'hf
   } jtp_state_type;

endpackage : jtp_pkg
`default_nettype wire

// ===== core/jtp_tap.sv
// Boundary-scan test access port: pin sampling, controller, serial path
//
// Summary of operation
// - Mode select is taken on every rising test-clock edge to steer the port.
// - Serial data input is taken on rising test-clock edges only in the two shift states.
// - Serial data output changes only on falling test-clock edges and on test reset.
// - Output stays high impedance except while a scan path is shifting.
// - Test reset low resets the port with no test-clock edge needed.
// - Undriven mode select and data inputs read as one (pull-ups).
`include "jtp_map.svh"
`default_nettype none
module jtp_tap
   import jtp_pkg::*;
#(
   parameter int IR_W = `JTP_IR_WIDTH
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire jtp_pins_type pins_i,
   output jtp_tdo_type tdo_o,
   output jtp_state_type state_o,
   output logic [IR_W-1:0] ir_o,
   output logic tlr_o
);

   // Next controller state for a given mode select level
   function automatic jtp_state_type tap_next(input jtp_state_type s,
                                              input logic m);
      unique case (s)
         JTP_TLR:        tap_next = m ? JTP_TLR : JTP_RTI;
         JTP_RTI:        tap_next = m ? JTP_SEL_DR : JTP_RTI;
         JTP_SEL_DR:     tap_next = m ? JTP_SEL_IR : JTP_CAPTURE_DR;
         JTP_CAPTURE_DR: tap_next = m ? JTP_EXIT1_DR : JTP_SHIFT_DR;
         JTP_SHIFT_DR:   tap_next = m ? JTP_EXIT1_DR : JTP_SHIFT_DR;
         JTP_EXIT1_DR:   tap_next = m ? JTP_UPDATE_DR : JTP_PAUSE_DR;
         JTP_PAUSE_DR:   tap_next = m ? JTP_EXIT2_DR : JTP_PAUSE_DR;
         JTP_EXIT2_DR:   tap_next = m ? JTP_UPDATE_DR : JTP_SHIFT_DR;
         JTP_UPDATE_DR:  tap_next = m ? JTP_SEL_DR : JTP_RTI;
         JTP_SEL_IR:     tap_next = m ? JTP_TLR : JTP_CAPTURE_IR;
         JTP_CAPTURE_IR: tap_next = m ? JTP_EXIT1_IR : JTP_SHIFT_IR;
         JTP_SHIFT_IR:   tap_next = m ? JTP_EXIT1_IR : JTP_SHIFT_IR;
         JTP_EXIT1_IR:   tap_next = m ? JTP_UPDATE_IR : JTP_PAUSE_IR;
         JTP_PAUSE_IR:   tap_next = m ? JTP_EXIT2_IR : JTP_PAUSE_IR;
         JTP_EXIT2_IR:   tap_next = m ? JTP_UPDATE_IR : JTP_SHIFT_IR;
         JTP_UPDATE_IR:  tap_next = m ? JTP_SEL_DR : JTP_RTI;
      endcase
   endfunction : tap_next

   jtp_pins_type pins_meta_r;
   jtp_pins_type pins_sync_r;
   logic tck_prev_r;
   logic tck_rise;
   logic tck_fall;
   logic tms_eff;
   logic tdi_eff;
   logic trst_low;
   logic shifting;
   logic serial_out;
   jtp_state_type state_r;
   logic [IR_W-1:0] ir_sh_r;
   logic [IR_W-1:0] ir_r;
   logic bypass_r;
   jtp_tdo_type tdo_r;

   // Two-stage synchroniser: the tester's pins are asynchronous to clk_i
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pins_meta_r <= '0;
         pins_sync_r <= '0;
      end else begin
         pins_meta_r <= pins_i;
         pins_sync_r <= pins_meta_r;
      end
   end

   // Previous test-clock level for edge detection
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tck_prev_r <= 1'h0;
      end else begin
         tck_prev_r <= pins_sync_r.tck;
      end
   end

   // Edge strobes, effective pin levels and the shifting condition
   assign tck_rise = pins_sync_r.tck & ~tck_prev_r;
   assign tck_fall = ~pins_sync_r.tck & tck_prev_r;
   assign tms_eff = pins_sync_r.tms_drv ? pins_sync_r.tms : 1'h1;
   assign tdi_eff = pins_sync_r.tdi_drv ? pins_sync_r.tdi : 1'h1;
   assign trst_low = ~pins_sync_r.trst_n;
   assign shifting = (state_r == JTP_SHIFT_DR) || (state_r == JTP_SHIFT_IR);
   assign serial_out = (state_r == JTP_SHIFT_IR) ? ir_sh_r[0] : bypass_r;

   // Controller; test reset acts on clk_i alone, no test-clock edge needed
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= JTP_TLR;
      end else if (trst_low) begin
         state_r <= JTP_TLR;
      end else if (tck_rise) begin
         state_r <= tap_next(state_r, tms_eff);
      end
   end

   // Instruction shifter: capture, shift from the data input, update
   always_ff @(posedge clk_i) begin
      if (rst_i || trst_low) begin
         ir_sh_r <= IR_W'(`JTP_IR_RESET);
         ir_r <= IR_W'(`JTP_IR_RESET);
      end else if (tck_rise) begin
         unique case (state_r)
            JTP_TLR: begin
               ir_r <= IR_W'(`JTP_IR_RESET);
            end
            JTP_CAPTURE_IR: begin
               ir_sh_r <= IR_W'(`JTP_IR_CAPTURE);
            end
            JTP_SHIFT_IR: begin
               ir_sh_r <= {tdi_eff, ir_sh_r[IR_W-1:1]};
            end
            JTP_UPDATE_IR: begin
               ir_r <= ir_sh_r;
            end
            default: begin
               ir_sh_r <= ir_sh_r;
            end
         endcase
      end
   end

   // Bypass stage is the only data path; instructions are not decoded here
   always_ff @(posedge clk_i) begin
      if (rst_i || trst_low) begin
         bypass_r <= `JTP_BYPASS_CAPTURE;
      end else if (tck_rise && state_r == JTP_CAPTURE_DR) begin
         bypass_r <= `JTP_BYPASS_CAPTURE;
      end else if (tck_rise && state_r == JTP_SHIFT_DR) begin
         bypass_r <= tdi_eff;
      end
   end

   // Output launched on the falling edge so the tester samples a settled
   // bit on the next rising edge; enable only while shifting
   always_ff @(posedge clk_i) begin
      if (rst_i || trst_low) begin
         tdo_r.data <= `JTP_TDO_RESET;
         tdo_r.oe <= `JTP_TDO_OE_RESET;
      end else if (tck_fall) begin
         tdo_r.data <= shifting ? serial_out : tdo_r.data;
         tdo_r.oe <= shifting;
      end
   end

   // Outputs straight from flip-flops
   assign tdo_o = tdo_r;
   assign state_o = state_r;
   assign ir_o = ir_r;

   // Test-logic-reset level for the rest of the chip
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tlr_o <= 1'h1;
      end else begin
         tlr_o <= (state_r == JTP_TLR);
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   // A rising edge with a given mode select level, no test reset
   sequence s_rise_tms(logic m);
      tck_rise && !trst_low && tms_eff == m;
   endsequence

   sequence s_fall_shift;
      tck_fall && !trst_low && shifting;
   endsequence

   property p_tlr_leave;
      (state_r == JTP_TLR) and s_rise_tms(1'h0) |=> state_r == JTP_RTI;
   endproperty
   a_tlr_leave: assert property (p_tlr_leave)
      else $error("controller did not leave reset on tms low");

   property p_seq_ir_path;
      (state_r == JTP_SEL_DR) and s_rise_tms(1'h1) |=>
         state_r == JTP_SEL_IR;
   endproperty
   a_seq_ir_path: assert property (p_seq_ir_path)
      else $error("select-dr with tms high did not go to select-ir");

   property p_no_edge_hold;
      !tck_rise && !trst_low |=> $stable(state_r);
   endproperty
   a_no_edge_hold: assert property (p_no_edge_hold)
      else $error("controller moved without a test-clock rise");

   property p_tdi_capture;
      (state_r == JTP_SHIFT_DR) and tck_rise && !trst_low |=>
         bypass_r == $past(tdi_eff);
   endproperty
   a_tdi_capture: assert property (p_tdi_capture)
      else $error("bypass stage did not take the data input");

   property p_tdo_on_fall;
      !$stable(tdo_o) |-> $past(tck_fall) || $past(trst_low);
   endproperty
   a_tdo_on_fall: assert property (p_tdo_on_fall)
      else $error("serial output changed away from a falling edge");

   property p_oe_shift;
      s_fall_shift |=> tdo_o.oe;
   endproperty
   a_oe_shift: assert property (p_oe_shift)
      else $error("output not enabled while shifting");

   property p_oe_idle;
      tck_fall && !shifting |=> !tdo_o.oe;
   endproperty
   a_oe_idle: assert property (p_oe_idle)
      else $error("output enabled outside a shift state");

   property p_trst;
      trst_low |=> state_r == JTP_TLR && !tdo_o.oe &&
         ir_r == IR_W'(`JTP_IR_RESET);
   endproperty
   a_trst: assert property (p_trst)
      else $error("test reset did not reset the port");

   property p_pullup;
      (state_r == JTP_RTI) && tck_rise && !trst_low &&
         !pins_sync_r.tms_drv |=> state_r == JTP_SEL_DR;
   endproperty
   a_pullup: assert property (p_pullup)
      else $error("undriven mode select not seen as one");

endmodule : jtp_tap
`default_nettype wire

// ===== dv/jtp_tester.sv
// Tester model: drives the test port pins and samples the serial output
`default_nettype none
module jtp_tester
   import jtp_pkg::*;
(
   input wire logic clk_i,
   input wire jtp_tdo_type tdo_i,
   output jtp_pins_type pins_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Clock stands low between frames; all lines driven at time zero
   initial pins_o = 6'b011111;

   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask : wait_clk

   // One 320 ns test-clock period; seen is the output left by the last fall
   task automatic cycle(input logic tms, input logic tdi, input logic tms_d,
                        input logic tdi_d, output jtp_tdo_type seen);
      pins_o.tms_drv = tms_d;
      pins_o.tdi_drv = tdi_d;
      // Released lines carry junk, so a design ignoring the flag is caught
      pins_o.tms = tms_d ? tms : ~pins_o.tms;
      pins_o.tdi = tdi_d ? tdi : ~pins_o.tdi;
      wait_clk(4);
      seen = tdo_i;
      pins_o.tck = 1'b1;
      wait_clk(4);
      pins_o.tck = 1'b0;
   endtask : cycle

   // Test reset held one full test-clock period, clock standing still
   task automatic treset();
      pins_o.trst_n = 1'b0;
      wait_clk(8);
      pins_o.trst_n = 1'b1;
      wait_clk(2);
   endtask : treset
endmodule : jtp_tester
`default_nettype wire

// ===== dv/test_boundary_scan_tap_pins.sv
// Testbench for the boundary-scan test port pin logic
`default_nettype none
module test_boundary_scan_tap_pins;
   import jtp_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   jtp_pins_type pins;
   jtp_tdo_type tdo;
   jtp_state_type state;
   logic [3:0] ir;
   logic tlr;
   int miscompares = 0;
   int num_checks = 0;
   // Controller successor for mode select low and high
   int n0[16] = '{1, 1, 3, 4, 4, 6, 6, 4, 1, 10, 11, 11, 13, 13, 11, 1};
   int n1[16] = '{0, 2, 9, 5, 5, 8, 7, 8, 2, 0, 12, 12, 15, 14, 15, 2};

   always #20 clk_i = ~clk_i;

   jtp_tap #(.IR_W(4)) uut (.clk_i(clk_i), .rst_i(rst_i), .pins_i(pins),
      .tdo_o(tdo), .state_o(state), .ir_o(ir), .tlr_o(tlr));
   jtp_tester tst (.clk_i(clk_i), .tdo_i(tdo), .pins_o(pins));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic report_and_stop();
      if (miscompares == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop

   // Guard against a hung run
   initial begin
      #200us;
      miscompares++;
      report_and_stop();
   end

   initial begin
      int st;
      int sh;
      int mir;
      int byp;
      int eoe;
      int ed;
      logic t;
      logic d;
      logic td;
      logic dd;
      jtp_tdo_type seen;
      st = 0;
      mir = 1;
      sh = 1;
      byp = 0;
      eoe = 0;
      ed = 0;
      void'($urandom(52278));
      repeat (8) @(posedge clk_i);
      #1;
      rst_i = 1'b0;
      repeat (3) @(posedge clk_i);
      #1;
      check({state, ir}, 8'h01);
      check({tdo.oe, tlr}, 8'h01);
      for (int i = 0; i < 240; i++) begin
         if (i % 60 == 59) begin
            // Test reset in mid-run, every 60th step, in whatever state the random walk has reached
            tst.treset();
            st = 0;
            mir = 1;
            eoe = 0;
            check({state, ir}, 8'h01);
            check(tdo.oe, 1'h0);
            continue;
         end
         t = ($urandom % 8) < 3;
         d = 1'($urandom);
         td = ($urandom % 8) != 0;
         dd = ($urandom % 8) != 0;
         tst.cycle(t, d, td, dd, seen);
         check(seen.oe, eoe[0]);
         if (eoe != 0) check(seen.data, ed[0]);
         // Reference step: pull-ups make released inputs read one
         t = td ? t : 1'b1;
         d = dd ? d : 1'b1;
         case (st)
            3: byp = 0;
            4: byp = d;
            10: sh = 1;
            11: sh = (sh >> 1) | (d << 3);
            15: mir = sh;
            default: ;
         endcase
         st = t ? n1[st] : n0[st];
         if (st == 0) mir = 1;
         eoe = (st == 4 || st == 11);
         if (st == 4) ed = byp;
         if (st == 11) ed = sh & 1;
         check(state, st[3:0]);
         check(tlr, st == 0);
         if (st != 0 && st != 15) check(ir, mir[3:0]);
      end
      report_and_stop();
   end
endmodule : test_boundary_scan_tap_pins
`default_nettype wire
